/* core/mlsm_monitor.sv */
// clock lock and sync monitor for a multichannel serial audio link
// Contract
// - legacy frame carries 28 pairs, 56 channels
// - legacy format tolerates rate within 12.5 percent
// - 64-channel format limited to 48k plus 1%
// - payload 100 Mbit/s, line runs 125 Mbit/s
// - carry 16 MIDI channels in user bits
// - lock on carrier match, hold through drift
// - report no lock, lock or sync per input
// - sync only when exactly synchronous to sample clock
// - master uses internal clock, follow mode uses input
// - monitoring delay three samples at single speed
// - monitoring delay six samples at double speed
`timescale 1ns/1ps
`default_nettype none
module mlsm_monitor #(
  parameter int FS_NOM_CYC = mlsm_pkg::NOM_FS_CYC,
  parameter int FS_MIN64_CYC = mlsm_pkg::MIN64_CYC,
  parameter int MON_W = 24
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  input wire logic madi_clk_i,
  input wire logic madi_fs_i,
  input wire logic word_clk_i,
  input wire logic frame_start_i,
  input wire logic ch_strobe_i,
  input wire logic ch_user_bit_i,
  input wire logic [MON_W-1:0] mon_data_i,
  output logic [MON_W-1:0] mon_data_o,
  output logic sample_tick_o,
  output logic midi_bit_o,
  output logic midi_valid_o,
  output logic irq_o
);
  localparam logic [15:0] NOM = 16'(FS_NOM_CYC);
  localparam logic [15:0] TOL = 16'(FS_NOM_CYC / mlsm_pkg::TOL_DIV);
  localparam logic [15:0] HI = NOM + TOL;
  localparam logic [15:0] LO = NOM - TOL;
  localparam logic [15:0] MIN64 = 16'(FS_MIN64_CYC);
  localparam logic [15:0] TMO = 16'(2 * FS_NOM_CYC);
  localparam logic [15:0] JIT = 16'(mlsm_pkg::JIT_CYC);
  localparam logic [15:0] WLAST = 16'(mlsm_pkg::WIN_CYC - 1);
  localparam logic [15:0] WEDG = 16'(mlsm_pkg::WIN_EDGES);
  localparam logic [15:0] LTOL = 16'(mlsm_pkg::LOCK_TOL);
  localparam logic [15:0] HTOL = 16'(mlsm_pkg::HOLD_TOL);
  localparam logic [15:0] DMIN = 16'(mlsm_pkg::DIV_MIN);
  localparam logic [2:0] SRUN = 3'(mlsm_pkg::SYNC_RUN);
  localparam logic [6:0] LIM56 = 7'(mlsm_pkg::CH_LEGACY);
  localparam logic [6:0] LIM64 = 7'(mlsm_pkg::CH_64);
  localparam logic [6:0] MIDX = 7'(mlsm_pkg::MIDI_CH_IDX);
  localparam logic [2:0] DSS = 3'(mlsm_pkg::DELAY_SS);
  localparam logic [2:0] DDS = 3'(mlsm_pkg::DELAY_DS);

  if (FS_NOM_CYC < 64 || 2 * FS_NOM_CYC > 65535 ||
      FS_MIN64_CYC > FS_NOM_CYC || FS_MIN64_CYC <= LO ||
      MON_W < 1) begin : g_bad
    $error("mlsm_monitor: parameters out of range");
  end

  function automatic logic [15:0] adiff(input logic [15:0] a,
                                        input logic [15:0] b);
    adiff = (a > b) ? a - b : b - a;
  endfunction

  function automatic mlsm_pkg::mlsm_clk_state_t enc_state(
      input logic lock, input logic sync);
    if (!lock) begin
      enc_state = mlsm_pkg::CLK_NO_LOCK;
    end else if (sync) begin
      enc_state = mlsm_pkg::CLK_SYNC;
    end else begin
      enc_state = mlsm_pkg::CLK_LOCK;
    end
  endfunction

  // pin synchronisers: carrier, frame rate clock, word clock
  logic [2:0] raw, s1, s2, s3, rise;
  assign raw = {word_clk_i, madi_fs_i, madi_clk_i};
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      s3 <= 3'h0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign rise = s2 & ~s3;

  // register state
  logic [2:0] ctrl, next_ctrl;
  logic [15:0] div, next_div;
  logic [4:0] ist, next_ist, imask, next_imask, ev;
  logic [31:0] rd, next_rd;
  logic follow_act, tick;
  logic [1:0] lock_v, lock_chg;
  logic [3:0] st_v;

  // carrier lock detector
  mlsm_pkg::mlsm_carr_t carr, next_carr;
  logic [15:0] win, next_win, edg, next_edg;
  logic carr_chg;
  always_comb begin
    next_win = win + 16'h0001;
    next_edg = edg + {15'h0, rise[0]};
    next_carr = carr;
    carr_chg = 1'b0;
    if (win == WLAST) begin
      next_win = 16'h0000;
      next_edg = 16'h0000;
      case (carr)
        mlsm_pkg::CR_HUNT: begin
          // link clock is 125 Mbit/s over four bits
          if (adiff(edg, WEDG) <= LTOL) begin
            next_carr = mlsm_pkg::CR_LOCK;
            carr_chg = 1'b1;
          end
        end
        mlsm_pkg::CR_LOCK: begin
          // wider hold window tracks drift
          if (adiff(edg, WEDG) > HTOL) begin
            next_carr = mlsm_pkg::CR_HUNT;
            carr_chg = 1'b1;
          end
        end
        default: begin
          next_carr = mlsm_pkg::CR_HUNT;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      carr <= mlsm_pkg::CR_HUNT;
      win <= 16'h0000;
      edg <= 16'h0000;
    end else begin
      carr <= next_carr;
      win <= next_win;
      edg <= next_edg;
    end
  end

  // per clock input: lock by period, sync by tick count per edge
  logic rate_ev;
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_mon
    logic [15:0] per, next_per, last, next_last, lo;
    logic lock, next_lock, in_rng;
    logic [1:0] tk, next_tk, iv;
    logic [2:0] run, next_run;
    logic car_ok;
    assign car_ok = (gi != 0) || (carr == mlsm_pkg::CR_LOCK);
    // 64-channel mode caps the rate, legacy allows 12.5 percent
    assign lo = ctrl[mlsm_pkg::CTRL_FMT64] ? MIN64 : LO;
    assign in_rng = (per >= lo) && (per <= HI);
    assign iv = tk + {1'b0, tick};
    always_comb begin
      next_per = (per == 16'hFFFF) ? per : per + 16'h0001;
      next_last = last;
      next_lock = lock;
      next_tk = tk;
      next_run = run;
      if (tick && tk != 2'h3) begin
        next_tk = tk + 2'h1;
      end
      if (rise[gi+1]) begin
        next_per = 16'h0001;
        next_last = per;
        // stable period in range means locked
        next_lock = car_ok && in_rng && (adiff(per, last) <= JIT);
        // a tick on the edge closes the old interval only
        next_tk = 2'h0;
        // exactly one sample tick per edge, four edges in a row, means sync
        if (next_lock && iv == 2'h1) begin
          if (run != 3'h7) begin
            next_run = run + 3'h1;
          end
        end else begin
          next_run = 3'h0;
        end
      end else if (per >= TMO || !car_ok) begin
        next_lock = 1'b0;
        next_run = 3'h0;
      end
    end
    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        per <= 16'h0000;
        last <= 16'h0000;
        lock <= 1'b0;
        tk <= 2'h0;
        run <= 3'h0;
      end else begin
        per <= next_per;
        last <= next_last;
        lock <= next_lock;
        tk <= next_tk;
        run <= next_run;
      end
    end
    assign lock_v[gi] = lock;
    assign lock_chg[gi] = lock ^ next_lock;
    assign st_v[2*gi+1:2*gi] = enc_state(lock, run >= SRUN);
    if (gi == 0) begin : g_madi
      assign rate_ev = rise[1] && car_ok && !in_rng;
    end
  end

  // sample clock: internal divider or recovered frame clock
  logic [15:0] dcnt, next_dcnt;
  logic int_tick;
  assign int_tick = (dcnt >= div - 16'h0001);
  always_comb begin
    next_dcnt = int_tick ? 16'h0000 : dcnt + 16'h0001;
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      dcnt <= 16'h0000;
    end else begin
      dcnt <= next_dcnt;
    end
  end
  // falls back to internal clock while the input is unlocked
  assign follow_act = ctrl[mlsm_pkg::CTRL_FOLLOW] && lock_v[0];
  assign tick = follow_act ? rise[1] : int_tick;
  assign sample_tick_o = tick;

  // frame channel count and hidden MIDI user bit
  logic [6:0] chn, next_chn, idx, lim;
  logic midi, next_midi, mval, next_mval, fmt_ev;
  assign idx = frame_start_i ? 7'h00 : chn;
  // legacy frame is 28 pairs, 56 channels
  assign lim = ctrl[mlsm_pkg::CTRL_FMT64] ? LIM64 : LIM56;
  always_comb begin
    next_chn = chn;
    next_midi = midi;
    next_mval = 1'b0;
    fmt_ev = 1'b0;
    if (frame_start_i) begin
      fmt_ev = chn > lim;
      next_chn = {6'h00, ch_strobe_i};
    end else if (ch_strobe_i && chn != 7'h7F) begin
      next_chn = chn + 7'h01;
    end
    // user bit of channel index 55, the last legacy channel, carries the MIDI stream
    if (ch_strobe_i && idx == MIDX) begin
      next_midi = ch_user_bit_i;
      next_mval = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      chn <= 7'h00;
      midi <= 1'b0;
      mval <= 1'b0;
    end else begin
      chn <= next_chn;
      midi <= next_midi;
      mval <= next_mval;
    end
  end
  assign midi_bit_o = midi;
  assign midi_valid_o = mval;

  // monitoring delay line, three or six samples
  logic [2:0] wp, next_wp, rp, dly;
  assign dly = ctrl[mlsm_pkg::CTRL_DOUBLE] ? DDS : DSS;
  assign rp = wp - dly;
  always_comb begin
    next_wp = tick ? wp + 3'h1 : wp;
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wp <= 3'h0;
    end else begin
      wp <= next_wp;
    end
  end
  mlsm_delay_mem #(
    .W(MON_W),
    .AW(3)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(tick),
    .waddr_i(wp),
    .wdata_i(mon_data_i),
    .re_i(tick),
    .raddr_i(rp),
    .rdata_o(mon_data_o)
  );

  // register file and interrupts
  logic wr_stat;
  logic [31:0] status;
  assign ev = {rate_ev, fmt_ev, carr_chg, lock_chg};
  assign wr_stat = reg_we_i && reg_addr_i == mlsm_pkg::REG_IRQ_STAT;
  assign status = {26'h0, follow_act, carr == mlsm_pkg::CR_LOCK, st_v};
  always_comb begin
    next_ctrl = ctrl;
    next_div = div;
    next_imask = imask;
    next_rd = 32'h0000_0000;
    // a new event wins over a write-one clear
    next_ist = (ist & ~(wr_stat ? reg_wdata_i[4:0] : 5'h00)) | ev;
    if (reg_we_i) begin
      case (reg_addr_i)
        mlsm_pkg::REG_CTRL: begin
          next_ctrl = reg_wdata_i[2:0];
        end
        mlsm_pkg::REG_IRQ_MASK: begin
          next_imask = reg_wdata_i[4:0];
        end
        mlsm_pkg::REG_DIV: begin
          next_div = (reg_wdata_i[15:0] < DMIN) ? DMIN
                                                : reg_wdata_i[15:0];
        end
        default: begin
          next_ctrl = ctrl;
        end
      endcase
    end
    if (reg_re_i) begin
      case (reg_addr_i)
        mlsm_pkg::REG_CTRL: next_rd = {29'h0, ctrl};
        mlsm_pkg::REG_STATUS: next_rd = status;
        mlsm_pkg::REG_IRQ_STAT: next_rd = {27'h0, ist};
        mlsm_pkg::REG_IRQ_MASK: next_rd = {27'h0, imask};
        mlsm_pkg::REG_DIV: next_rd = {16'h0, div};
        default: next_rd = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl <= mlsm_pkg::CTRL_RST;
      div <= NOM;
      ist <= 5'h00;
      imask <= 5'h00;
      rd <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      div <= next_div;
      ist <= next_ist;
      imask <= next_imask;
      rd <= next_rd;
    end
  end
  assign reg_rdata_o = rd;
  assign irq_o = |(ist & imask);
endmodule
`default_nettype wire

/* core/mlsm_pkg.sv */
// constants and types shared by the lock and sync monitor
package mlsm_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int FS_NOM_HZ = 48_000;
  // 64-channel ceiling: 48 kHz plus one percent
  localparam int FS_MAX64_HZ = 48_480;
  localparam int NOM_FS_CYC = CLK_HZ / FS_NOM_HZ;
  localparam int MIN64_CYC = (CLK_HZ + FS_MAX64_HZ - 1) / FS_MAX64_HZ;
  // 12.5 percent is one eighth
  localparam int TOL_DIV = 8;
  localparam int PAYLOAD_BPS = 100_000_000;
  localparam int LINE_BPS = 125_000_000;
  localparam int BITS_PER_LINK_CLK = 4;
  localparam int LINK_HZ = LINE_BPS / BITS_PER_LINK_CLK;
  localparam int WIN_CYC = 1024;
  localparam int WIN_EDGES = WIN_CYC / (CLK_HZ / LINK_HZ);
  localparam int LOCK_TOL = 4;
  localparam int HOLD_TOL = 12;
  localparam int JIT_CYC = 2;
  localparam int SYNC_RUN = 4;
  localparam int PAIRS_LEGACY = 28;
  localparam int CH_LEGACY = 2 * PAIRS_LEGACY;
  localparam int CH_64 = 64;
  localparam int MIDI_CHANNELS = 16;
  localparam int MIDI_CH_IDX = CH_LEGACY - 1;
  localparam int DELAY_SS = 3;
  localparam int DELAY_DS = 6;
  localparam int DIV_MIN = 2;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_DIV = 8'h10;
  // control fields
  localparam int CTRL_FOLLOW = 0;
  localparam int CTRL_DOUBLE = 1;
  localparam int CTRL_FMT64 = 2;
  localparam int CTRL_W = 3;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // status fields
  localparam int ST_MADI = 0;
  localparam int ST_WORD = 2;
  localparam int ST_CARR = 4;
  localparam int ST_FOLLOW = 5;
  // interrupt bits
  localparam int IRQ_MADI = 0;
  localparam int IRQ_WORD = 1;
  localparam int IRQ_CARR = 2;
  localparam int IRQ_FMT = 3;
  localparam int IRQ_RATE = 4;
  localparam int IRQ_W = 5;
  typedef enum logic [1:0] {
    CLK_NO_LOCK = 2'h0,
    CLK_LOCK = 2'h1,
    CLK_SYNC = 2'h2
  } mlsm_clk_state_t;
  typedef enum logic [1:0] {
    CR_HUNT = 2'b01,
    CR_LOCK = 2'b10
  } mlsm_carr_t;
endpackage

/* core/mlsm_delay_mem.sv */
// small sample memory for the monitoring delay line
`timescale 1ns/1ps
`default_nettype none
module mlsm_delay_mem #(
  parameter int W = 24,
  parameter int AW = 3
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic re_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] mem [2**AW];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule
`default_nettype wire

/* dv/mlsm_far_end.sv */
// far-end link model: carrier clock and recovered frame rate
`timescale 1ns/1ps
`default_nettype none
module mlsm_far_end (
  input wire logic clk_i,
  input wire logic carrier_on_i,
  input wire logic [15:0] fs_period_i,
  output logic madi_clk_o,
  output logic madi_fs_o
);
  logic [15:0] cnt = 16'h0000;
  initial begin
    madi_clk_o = 1'b0;
    #1.3;
    // 125 Mbit/s line, four bits per carrier period
    forever #16 madi_clk_o = carrier_on_i ? ~madi_clk_o : 1'b0;
  end
  // frame rate in clock cycles, steady period
  always @(posedge clk_i) begin
    cnt <= (cnt >= fs_period_i - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
    madi_fs_o <= (cnt < fs_period_i / 2);
  end
endmodule
`default_nettype wire

/* dv/mlsm_monitor_sva.sv */
// port checker for the lock and sync monitor
`timescale 1ns/1ps
`default_nettype none
module mlsm_monitor_chk #(
  parameter int MON_W = 24
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic ch_strobe_i,
  input wire logic [MON_W-1:0] mon_data_o,
  input wire logic sample_tick_o,
  input wire logic midi_valid_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic rd_st;
  assign rd_st = reg_re_i && reg_addr_i == mlsm_pkg::REG_STATUS;
  property p_rdata_idle;
    !$past(reg_re_i) |-> reg_rdata_o == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read cycle");
  property p_unmapped;
    reg_re_i && reg_addr_i == 8'h14 |=> reg_rdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_code;
    rd_st |=> reg_rdata_o[1:0] != 2'h3 && reg_rdata_o[3:2] != 2'h3;
  endproperty
  a_code: assert property (p_code)
    else $error("illegal clock state code");
  property p_sync_carr;
    rd_st |=> reg_rdata_o[1:0] == 2'h0 || reg_rdata_o[4];
  endproperty
  a_sync_carr: assert property (p_sync_carr)
    else $error("link input locked without carrier");
  property p_midi;
    midi_valid_o |-> $past(ch_strobe_i) && !$past(midi_valid_o);
  endproperty
  a_midi: assert property (p_midi)
    else $error("midi valid without strobe");
  property p_tick;
    sample_tick_o |=> !sample_tick_o;
  endproperty
  a_tick: assert property (p_tick)
    else $error("sample tick longer than one cycle");
  property p_mon;
    $changed(mon_data_o) |-> $past(sample_tick_o);
  endproperty
  a_mon: assert property (p_mon)
    else $error("monitor output changed without tick");
  property p_irq_mask0;
    reg_we_i && reg_addr_i == mlsm_pkg::REG_IRQ_MASK
      && reg_wdata_i == 32'h0000_0000 |=> !irq_o;
  endproperty
  a_irq_mask0: assert property (p_irq_mask0)
    else $error("interrupt high with mask cleared");
  property p_div_floor;
    reg_we_i && reg_addr_i == mlsm_pkg::REG_DIV && reg_wdata_i < 32'h0000_0002
      ##2 reg_re_i && reg_addr_i == mlsm_pkg::REG_DIV
      |=> reg_rdata_o == 32'h0000_0002;
  endproperty
  a_div_floor: assert property (p_div_floor)
    else $error("divider floor not applied");
endmodule
bind mlsm_monitor mlsm_monitor_chk #(.MON_W(MON_W)) i_mlsm_monitor_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .ch_strobe_i(ch_strobe_i),
  .mon_data_o(mon_data_o), .sample_tick_o(sample_tick_o),
  .midi_valid_o(midi_valid_o), .irq_o(irq_o)
);
`default_nettype wire

/* dv/tb_mlsm_monitor.sv */
// register-level bench for the lock and sync monitor
`timescale 1ns/1ps
`default_nettype none
module tb_mlsm_monitor;
  logic clk_i, reset_n_i, we, re, fstart, strobe, ubit, carr_on;
  logic madi_clk, madi_fs, tick, mbit, mvalid, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [15:0] fs_per;
  logic [23:0] mon, mon_o;
  int n_fail, num_checks;
  mlsm_monitor #(.FS_NOM_CYC(200), .FS_MIN64_CYC(190)) i_mlsm_monitor (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
    .madi_clk_i(madi_clk), .madi_fs_i(madi_fs), .word_clk_i(madi_fs),
    .frame_start_i(fstart), .ch_strobe_i(strobe), .ch_user_bit_i(ubit),
    .mon_data_i(mon), .mon_data_o(mon_o), .sample_tick_o(tick),
    .midi_bit_o(mbit), .midi_valid_o(mvalid), .irq_o(irq)
  );
  mlsm_far_end i_mlsm_far_end (
    .clk_i(clk_i), .carrier_on_i(carr_on), .fs_period_i(fs_per),
    .madi_clk_o(madi_clk), .madi_fs_o(madi_fs)
  );
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (tick === 1'b1) mon <= mon + 24'h00_0001;
  end
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    we <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk_i);
    we <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_i);
    re <= 1'b1; addr <= a;
    @(posedge clk_i);
    re <= 1'b0;
    #1 chk(nm, e, rdata & m);
  endtask
  task automatic tick_wait;
    do @(negedge clk_i); while (tick !== 1'b1);
  endtask
  task automatic mon_chk(input int d);
    logic [23:0] v;
    repeat (d + 1) tick_wait();
    tick_wait();
    v = mon;
    repeat (d) tick_wait();
    @(negedge clk_i);
    chk("mon_data", {8'h00, v}, {8'h00, mon_o});
  endtask
  task automatic frame(input int n, input logic ub);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      fstart <= (i == 0); strobe <= 1'b1; ubit <= (i == 55) ? ub : ~ub;
    end
    @(posedge clk_i);
    fstart <= 1'b0; strobe <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {reset_n_i, we, re, fstart, strobe, ubit, carr_on} = 7'h00;
    addr = 8'h00; wdata = 32'h0000_0000; fs_per = 16'h00C8; mon = 24'h00_0000;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdchk("ctrl", mlsm_pkg::REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk("mask", mlsm_pkg::REG_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk("status", mlsm_pkg::REG_STATUS, 32'h0000_003F, 32'h0000_0000);
    rdchk("unmapped", 8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(mlsm_pkg::REG_DIV, 32'h0000_0001);
    rdchk("div_floor", mlsm_pkg::REG_DIV, 32'hFFFF_FFFF, 32'h0000_0002);
    // two internal ticks per input period: locked, never in step
    wr(mlsm_pkg::REG_DIV, 32'h0000_0064);
    carr_on <= 1'b1;
    repeat (4000) @(posedge clk_i);
    rdchk("status_lock", mlsm_pkg::REG_STATUS, 32'h3F, 32'h15);
    rdchk("irq_stat", mlsm_pkg::REG_IRQ_STAT, 32'h07, 32'h07);
    wr(mlsm_pkg::REG_IRQ_MASK, 32'h0000_0004);
    @(negedge clk_i);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(mlsm_pkg::REG_IRQ_STAT, 32'h0000_0004);
    @(negedge clk_i);
    chk("irq_off", 32'h0, {31'h0, irq});
    wr(mlsm_pkg::REG_IRQ_MASK, 32'h0000_0000);
    wr(mlsm_pkg::REG_CTRL, 32'h0000_0001);
    repeat (3000) @(posedge clk_i);
    rdchk("status_sync", mlsm_pkg::REG_STATUS, 32'h3F, 32'h3A);
    mon_chk(3);
    wr(mlsm_pkg::REG_CTRL, 32'h0000_0003);
    mon_chk(6);
    frame(56, 1'b1);
    chk("midi_one", 32'h1, {31'h0, mbit});
    frame(56, 1'b0);
    chk("midi_zero", 32'h0, {31'h0, mbit});
    frame(57, 1'b1);
    frame(56, 1'b1);
    rdchk("overflow", mlsm_pkg::REG_IRQ_STAT, 32'h08, 32'h08);
    // period 180 is legal for the legacy format but too fast for 64 channels
    wr(mlsm_pkg::REG_IRQ_STAT, 32'h0000_001F);
    wr(mlsm_pkg::REG_CTRL, 32'h0000_0004);
    fs_per <= 16'h00B4;
    repeat (1000) @(posedge clk_i);
    rdchk("rate64", mlsm_pkg::REG_IRQ_STAT, 32'h10, 32'h10);
    rdchk("status_fmt64", mlsm_pkg::REG_STATUS, 32'h0F, 32'h00);
    wr(mlsm_pkg::REG_CTRL, 32'h0000_0000);
    repeat (1000) @(posedge clk_i);
    rdchk("status_legacy", mlsm_pkg::REG_STATUS, 32'h0F, 32'h05);
    tally_and_finish();
  end
endmodule
`default_nettype wire
